// ### core/port_pad_config_regs.sv
// How it works
// [R1] Six-bit polarity picks pull-up or pull-down
// [R2] Open-drain bit: drive low only, else push-pull
// [R3] Open-drain bit ignored on input pins
// [R4] Data read: latch if output, else pin
// [R5] Pin mirror is read-only, writes discarded
// [R6] Pin mirror returns real pad levels always
// [R7] Direction bit: 0 input, 1 output
// [R8] Pin reads lag pad levels by two cycles; a direction change switches latch or pin at once
// [R9] Reduced drive bit ignored on inputs
// [R10] Byte pull enable acts on inputs only
// [R11] Byte port pulls disabled after reset
// [R12] Byte polarity picks pull and active edge
// [R13] Six-bit pulls on after reset, not push-pull
// [R14] Every config bit drives a pad control
// [R15] Data resets zero, mirror follows live pins
//
// Our own choice: the APB interface to the registers.
module port_pad_config_regs #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned BYTE_W = 8,
  parameter int unsigned SIX_W  = 6
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  // Byte port pads
  input  wire logic [BYTE_W-1:0] byte_pin_in,
  output logic      [BYTE_W-1:0] byte_pad_out,
  output logic      [BYTE_W-1:0] byte_pad_oe,
  output logic      [BYTE_W-1:0] byte_pad_reduced,
  output logic      [BYTE_W-1:0] byte_pad_pull_up,
  output logic      [BYTE_W-1:0] byte_pad_pull_down,
  output logic      [BYTE_W-1:0] byte_edge_rising,
  // Six-bit port pads; data and direction come from its own registers
  input  wire logic [SIX_W-1:0]  six_port_out,
  input  wire logic [SIX_W-1:0]  six_port_dir,
  output logic      [SIX_W-1:0]  six_pad_out,
  output logic      [SIX_W-1:0]  six_pad_oe,
  output logic      [SIX_W-1:0]  six_pad_pull_up,
  output logic      [SIX_W-1:0]  six_pad_pull_down
);

  // Elaboration checks
  if (ADDR_W < 7 || ADDR_W > 16) begin : g_bad_addr
    $error("ADDR_W must be 7 to 16 to reach every register");
  end
  if (BYTE_W < 1 || BYTE_W > port_pad_pkg::DATA_W) begin : g_bad_byte
    $error("BYTE_W must be 1 to 8");
  end
  if (SIX_W < 1 || SIX_W > port_pad_pkg::DATA_W) begin : g_bad_six
    $error("SIX_W must be 1 to 8");
  end

  // Word index of a byte address, all-ones when misaligned
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
    logic [31:0] shifted;
    // Widened first so every legal ADDR_W, even below eight, fits
    shifted = 32'(a) >> 2;
    if (a[1:0] != 2'b00 || shifted > 32'h0000_00ff) begin
      return 8'hff;
    end
    return shifted[7:0];
  endfunction : word_index

  // Pick latch or pin per bit depending on direction
  function automatic logic [BYTE_W-1:0] dir_mux(
    input logic [BYTE_W-1:0] dir,
    input logic [BYTE_W-1:0] latch,
    input logic [BYTE_W-1:0] pins
  );
    return (dir & latch) | (~dir & pins);
  endfunction : dir_mux

  // Configuration registers
  logic [BYTE_W-1:0] byte_port_data;
  logic [BYTE_W-1:0] byte_port_direction;
  logic [BYTE_W-1:0] byte_port_drive_strength;
  logic [BYTE_W-1:0] byte_port_pull_enable;
  logic [BYTE_W-1:0] byte_port_pull_polarity;
  logic [SIX_W-1:0]  six_bit_port_pull_enable;
  logic [SIX_W-1:0]  six_bit_port_pull_polarity;
  logic [SIX_W-1:0]  six_bit_port_open_drain;

  // Synchronised pad levels
  logic [BYTE_W-1:0] byte_pin_sync;

  // Bus decode
  port_pad_pkg::apb_phase_t phase;
  port_pad_pkg::apb_phase_t next_phase;
  logic [7:0]               idx;
  logic                     access;
  logic                     wr_en;
  logic [7:0]               wr_byte;
  logic                     mapped;
  logic [31:0]              next_prdata;

  // Next values of the pad controls
  logic [BYTE_W-1:0] next_byte_pad_out;
  logic [BYTE_W-1:0] next_byte_pad_oe;
  logic [BYTE_W-1:0] next_byte_pad_reduced;
  logic [BYTE_W-1:0] next_byte_pad_pull_up;
  logic [BYTE_W-1:0] next_byte_pad_pull_down;
  logic [SIX_W-1:0]  next_six_pad_out;
  logic [SIX_W-1:0]  next_six_pad_oe;
  logic [SIX_W-1:0]  next_six_pad_pull_up;
  logic [SIX_W-1:0]  next_six_pad_pull_down;
  logic [BYTE_W-1:0] byte_pull_on;
  logic [SIX_W-1:0]  six_pull_on;

  // Pads pass two flops before any read sees them
  pin_sync #(
    .WIDTH    (BYTE_W)
  ) u_byte_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (byte_pin_in),
    .sync_out (byte_pin_sync)                   // see [R8]
  );

  // Decode of the access phase
  assign idx     = word_index(paddr);
  assign access  = psel && penable;
  // Write lands only at the edge where pready is sampled high
  assign wr_en   = access && pready && pwrite && pstrb[0];
  assign wr_byte = pwdata[port_pad_pkg::DATA_LSB +: 8];

  // Which indices answer without error
  always_comb begin
    case (idx)
      port_pad_pkg::IDX_SIX_PULL_EN,
      port_pad_pkg::IDX_SIX_POLARITY,
      port_pad_pkg::IDX_SIX_OPEN_DRAIN,
      port_pad_pkg::IDX_BYTE_DATA,
      port_pad_pkg::IDX_BYTE_MIRROR,
      port_pad_pkg::IDX_BYTE_DIR,
      port_pad_pkg::IDX_BYTE_DRIVE,
      port_pad_pkg::IDX_BYTE_PULL_EN,
      port_pad_pkg::IDX_BYTE_POLARITY: mapped = 1'b1;
      default:                         mapped = 1'b0;
    endcase
  end

  // Read data; narrow registers zero-extend
  always_comb begin
    case (idx)
      port_pad_pkg::IDX_SIX_PULL_EN:
        next_prdata = 32'(six_bit_port_pull_enable);
      port_pad_pkg::IDX_SIX_POLARITY:
        next_prdata = 32'(six_bit_port_pull_polarity);
      port_pad_pkg::IDX_SIX_OPEN_DRAIN:
        next_prdata = 32'(six_bit_port_open_drain);
      port_pad_pkg::IDX_BYTE_DATA:                 // see [R4]
        next_prdata = 32'(dir_mux(byte_port_direction, byte_port_data,
                                  byte_pin_sync));
      port_pad_pkg::IDX_BYTE_MIRROR:               // see [R6]
        next_prdata = 32'(byte_pin_sync);
      port_pad_pkg::IDX_BYTE_DIR:
        next_prdata = 32'(byte_port_direction);
      port_pad_pkg::IDX_BYTE_DRIVE:
        next_prdata = 32'(byte_port_drive_strength);
      port_pad_pkg::IDX_BYTE_PULL_EN:
        next_prdata = 32'(byte_port_pull_enable);
      port_pad_pkg::IDX_BYTE_POLARITY:
        next_prdata = 32'(byte_port_pull_polarity);
      default:
        next_prdata = 32'h0000_0000;
    endcase
  end

  // Answer one cycle into the access phase
  always_comb begin
    case (phase)
      port_pad_pkg::APB_IDLE:
        next_phase = access ? port_pad_pkg::APB_ANSWER
                            : port_pad_pkg::APB_IDLE;
      port_pad_pkg::APB_ANSWER:
        next_phase = port_pad_pkg::APB_IDLE;
      default:
        next_phase = port_pad_pkg::APB_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase <= port_pad_pkg::APB_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // Bus outputs all registered; read data frozen with pready
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (phase == port_pad_pkg::APB_IDLE && access) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= !mapped;
    end else begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // Output latch of the byte port
  always_ff @(posedge clk) begin
    if (!resetn) begin
      byte_port_data <= port_pad_pkg::RST_BYTE_DATA[BYTE_W-1:0]; // see [R15]
    end else if (wr_en && idx == port_pad_pkg::IDX_BYTE_DATA) begin
      byte_port_data <= wr_byte[BYTE_W-1:0];
    end
  end

  // Direction of the byte port
  always_ff @(posedge clk) begin
    if (!resetn) begin
      byte_port_direction <= port_pad_pkg::RST_BYTE_DIR[BYTE_W-1:0];
    end else if (wr_en && idx == port_pad_pkg::IDX_BYTE_DIR) begin
      byte_port_direction <= wr_byte[BYTE_W-1:0];
    end
  end

  // Reduced drive of the byte port
  always_ff @(posedge clk) begin
    if (!resetn) begin
      byte_port_drive_strength <= port_pad_pkg::RST_BYTE_DRIVE[BYTE_W-1:0];
    end else if (wr_en && idx == port_pad_pkg::IDX_BYTE_DRIVE) begin
      byte_port_drive_strength <= wr_byte[BYTE_W-1:0];
    end
  end

  // Pull enables of the byte port, all off out of reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      byte_port_pull_enable <=
        port_pad_pkg::RST_BYTE_PULL_EN[BYTE_W-1:0];          // see [R11]
    end else if (wr_en && idx == port_pad_pkg::IDX_BYTE_PULL_EN) begin
      byte_port_pull_enable <= wr_byte[BYTE_W-1:0];
    end
  end

  // Pull and edge polarity of the byte port
  always_ff @(posedge clk) begin
    if (!resetn) begin
      byte_port_pull_polarity <=
        port_pad_pkg::RST_BYTE_POLARITY[BYTE_W-1:0];
    end else if (wr_en && idx == port_pad_pkg::IDX_BYTE_POLARITY) begin
      byte_port_pull_polarity <= wr_byte[BYTE_W-1:0];
    end
  end

  // Pull enables of the six-bit port, pull-ups on out of reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      six_bit_port_pull_enable <=
        port_pad_pkg::RST_SIX_PULL_EN[SIX_W-1:0];            // see [R13]
    end else if (wr_en && idx == port_pad_pkg::IDX_SIX_PULL_EN) begin
      six_bit_port_pull_enable <= wr_byte[SIX_W-1:0];
    end
  end

  // Pull polarity of the six-bit port
  always_ff @(posedge clk) begin
    if (!resetn) begin
      six_bit_port_pull_polarity <=
        port_pad_pkg::RST_SIX_POLARITY[SIX_W-1:0];
    end else if (wr_en && idx == port_pad_pkg::IDX_SIX_POLARITY) begin
      six_bit_port_pull_polarity <= wr_byte[SIX_W-1:0];
    end
  end

  // Open-drain mode of the six-bit port
  always_ff @(posedge clk) begin
    if (!resetn) begin
      six_bit_port_open_drain <=
        port_pad_pkg::RST_SIX_OPEN_DRAIN[SIX_W-1:0];
    end else if (wr_en && idx == port_pad_pkg::IDX_SIX_OPEN_DRAIN) begin
      six_bit_port_open_drain <= wr_byte[SIX_W-1:0];
    end
  end
  // Mirror index has no write branch: a write there changes nothing,
  // yet still gets an OKAY answer since the address is mapped. see [R5]

  // Byte port pad controls
  always_comb begin
    next_byte_pad_out     = byte_port_data;
    next_byte_pad_oe      = byte_port_direction;               // see [R7]
    // Drive strength only matters on an output
    next_byte_pad_reduced = byte_port_drive_strength
                          & byte_port_direction;               // see [R9]
    // Pull only on an input; polarity 0 up, 1 down
    byte_pull_on          = byte_port_pull_enable
                          & ~byte_port_direction;              // see [R10]
    next_byte_pad_pull_up   = byte_pull_on & ~byte_port_pull_polarity;
    next_byte_pad_pull_down = byte_pull_on
                            & byte_port_pull_polarity;         // see [R12]
  end

  // Six-bit port pad controls
  always_comb begin
    // Open drain never drives a high; inputs keep oe low anyway
    next_six_pad_oe  = six_port_dir
                     & (~six_bit_port_open_drain | ~six_port_out); // see [R2]
    next_six_pad_out = six_port_out & ~six_bit_port_open_drain;
    // Input pins see no effect of the open-drain bit via oe gating
    // above: dir low forces oe low whatever that bit holds. see [R3]
    six_pull_on      = six_bit_port_pull_enable
                     & (~six_port_dir | six_bit_port_open_drain); // see [R13]
    next_six_pad_pull_up   = six_pull_on & ~six_bit_port_pull_polarity;
    next_six_pad_pull_down = six_pull_on
                           & six_bit_port_pull_polarity;       // see [R1]
  end

  // All pad controls leave through flops, one cycle after the register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      byte_pad_out       <= '0;
      byte_pad_oe        <= '0;
      byte_pad_reduced   <= '0;
      byte_pad_pull_up   <= '0;
      byte_pad_pull_down <= '0;
      byte_edge_rising   <= '0;
    end else begin
      byte_pad_out       <= next_byte_pad_out;                 // see [R14]
      byte_pad_oe        <= next_byte_pad_oe;
      byte_pad_reduced   <= next_byte_pad_reduced;
      byte_pad_pull_up   <= next_byte_pad_pull_up;
      byte_pad_pull_down <= next_byte_pad_pull_down;
      // Same bit picks the active edge for the edge detector
      byte_edge_rising   <= byte_port_pull_polarity;           // see [R12]
    end
  end

  // Six-bit pads; all controls read zero in reset, pull-ups included, though the pull-enable register resets to 3f
  always_ff @(posedge clk) begin
    if (!resetn) begin
      six_pad_out       <= '0;
      six_pad_oe        <= '0;
      six_pad_pull_up   <= '0;
      six_pad_pull_down <= '0;
    end else begin
      six_pad_out       <= next_six_pad_out;                   // see [R14]
      six_pad_oe        <= next_six_pad_oe;
      six_pad_pull_up   <= next_six_pad_pull_up;
      six_pad_pull_down <= next_six_pad_pull_down;
    end
  end

endmodule : port_pad_config_regs

// ### core/port_pad_pkg.sv
package port_pad_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_SIX_PULL_EN    = 8'h14;
  localparam logic [7:0] IDX_SIX_POLARITY   = 8'h15;
  localparam logic [7:0] IDX_SIX_OPEN_DRAIN = 8'h16;
  localparam logic [7:0] IDX_BYTE_DATA      = 8'h18;
  localparam logic [7:0] IDX_BYTE_MIRROR    = 8'h19;
  localparam logic [7:0] IDX_BYTE_DIR       = 8'h1a;
  localparam logic [7:0] IDX_BYTE_DRIVE     = 8'h1b;
  localparam logic [7:0] IDX_BYTE_PULL_EN   = 8'h1c;
  localparam logic [7:0] IDX_BYTE_POLARITY  = 8'h1d;

  // Byte lane holding register data
  localparam int unsigned DATA_LSB = 0;
  localparam int unsigned DATA_W   = 8;

  // Values after reset
  localparam logic [7:0] RST_SIX_PULL_EN    = 8'h3f;
  localparam logic [7:0] RST_SIX_POLARITY   = 8'h00;
  localparam logic [7:0] RST_SIX_OPEN_DRAIN = 8'h00;
  localparam logic [7:0] RST_BYTE_DATA      = 8'h00;
  localparam logic [7:0] RST_BYTE_DIR       = 8'h00;
  localparam logic [7:0] RST_BYTE_DRIVE     = 8'h00;
  localparam logic [7:0] RST_BYTE_PULL_EN   = 8'h00;
  localparam logic [7:0] RST_BYTE_POLARITY  = 8'h00;
  localparam logic       RST_SYNC           = 1'b0;

  // Flip-flops between a pad and the read path
  localparam int unsigned SYNC_STAGES = 2;

  // Bus answer sequencing
  typedef enum logic [0:0] {
    APB_IDLE,
    APB_ANSWER
  } apb_phase_t;

endpackage : port_pad_pkg

// ### core/pin_sync.sv
module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // Two flops; the first is read only by the second
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage_one <= {WIDTH{port_pad_pkg::RST_SYNC}};
      sync_out  <= {WIDTH{port_pad_pkg::RST_SYNC}};
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule : pin_sync

// ### tb/port_pad_assertions.sv
module port_pad_assertions #(
  parameter int unsigned BYTE_W = 8,
  parameter int unsigned SIX_W  = 6
) (
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic [BYTE_W-1:0] byte_pad_oe,
  input wire logic [BYTE_W-1:0] byte_pad_reduced,
  input wire logic [BYTE_W-1:0] byte_pad_pull_up,
  input wire logic [BYTE_W-1:0] byte_pad_pull_down,
  input wire logic [BYTE_W-1:0] byte_edge_rising,
  input wire logic [SIX_W-1:0]  six_port_out,
  input wire logic [SIX_W-1:0]  six_port_dir,
  input wire logic [SIX_W-1:0]  six_pad_out,
  input wire logic [SIX_W-1:0]  six_pad_oe,
  input wire logic [SIX_W-1:0]  six_pad_pull_up,
  input wire logic [SIX_W-1:0]  six_pad_pull_down
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Pad controls; all are registered from the same cycle's state
  a_one_pull: assert property (
    (((six_pad_pull_up & six_pad_pull_down) == '0) &&
     ((byte_pad_pull_up & byte_pad_pull_down) == '0)))
    else $error("both pulls on one pin");
  a_od_drive: assert property (
    (six_pad_oe & $past(six_port_out) & ~six_pad_out) == '0)
    else $error("driven one not from push-pull");
  a_od_input: assert property (
    (six_pad_oe & ~$past(six_port_dir)) == '0)
    else $error("input pin driven");
  a_pp_no_pull: assert property (
    ((six_pad_pull_up | six_pad_pull_down) & six_pad_oe &
     $past(six_port_out)) == '0)
    else $error("pull on push-pull output");
  a_byte_pull_in: assert property (
    ((byte_pad_pull_up | byte_pad_pull_down) & byte_pad_oe) == '0)
    else $error("byte pull on output");
  a_reduce_out: assert property (
    (byte_pad_reduced & ~byte_pad_oe) == '0)
    else $error("reduced drive on input");
  a_pol_shared: assert property (
    ((byte_pad_pull_down & ~byte_edge_rising) |
     (byte_pad_pull_up & byte_edge_rising)) == '0)
    else $error("pull and edge disagree");

  // Bus answer timing and idle values
  a_ready_next: assert property (
    psel && penable && !pready |=> pready)
    else $error("no answer after first access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_data_idle: assert property (!pready |-> prdata == '0)
    else $error("read data outside answer");

  c_err: cover property (pslverr);
  c_read: cover property (pready && prdata != '0);
  c_six_down: cover property (six_pad_pull_down != '0);
endmodule : port_pad_assertions

// ### tb/pad_model.sv
module pad_model (
  input  wire logic       clk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pull_up,
  input  wire logic [7:0] pull_down,
  input  wire logic [7:0] ext_on,
  input  wire logic [7:0] ext_level,
  input  wire logic [7:0] short_low,
  output logic      [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] drift = 8'h55;

  // Floating pins wander so a stale level never looks valid
  always @(posedge clk) drift <= ~drift;

  // Short wins, then own driver, outside driver, pull, else floating
  assign pin = ~short_low & ((pad_oe & pad_out)
             | (~pad_oe & ext_on & ext_level)
             | (~pad_oe & ~ext_on
                & (pull_up | (~pull_down & drift))));
endmodule : pad_model

// ### tb/port_pad_config_regs_bench.sv
module port_pad_config_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] SPE  = port_pad_pkg::IDX_SIX_PULL_EN << 2;
  localparam logic [7:0] SPOL = port_pad_pkg::IDX_SIX_POLARITY << 2;
  localparam logic [7:0] SOD  = port_pad_pkg::IDX_SIX_OPEN_DRAIN << 2;
  localparam logic [7:0] BDAT = port_pad_pkg::IDX_BYTE_DATA << 2;
  localparam logic [7:0] BMIR = port_pad_pkg::IDX_BYTE_MIRROR << 2;
  localparam logic [7:0] BDIR = port_pad_pkg::IDX_BYTE_DIR << 2;
  localparam logic [7:0] BDRV = port_pad_pkg::IDX_BYTE_DRIVE << 2;
  localparam logic [7:0] BPE  = port_pad_pkg::IDX_BYTE_PULL_EN << 2;
  localparam logic [7:0] BPOL = port_pad_pkg::IDX_BYTE_POLARITY << 2;
  logic        clk = 1'b0, resetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr;
  logic [31:0] prdata;
  logic [7:0]  byte_pin_in, byte_pad_out, byte_pad_oe, byte_pad_reduced;
  logic [7:0]  byte_pad_pull_up, byte_pad_pull_down, byte_edge_rising;
  logic [5:0]  six_port_out = 6'h00, six_port_dir = 6'h00;
  logic [5:0]  six_pad_out, six_pad_oe, six_pad_pull_up, six_pad_pull_down;
  logic [7:0]  ext_on = 8'hff, ext_level = 8'ha5, short_low = 8'h00;
  int          n_fail = 0, comparisons = 0, cycles = 0;

  port_pad_config_regs dut (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .byte_pin_in(byte_pin_in), .byte_pad_out(byte_pad_out),
    .byte_pad_oe(byte_pad_oe), .byte_pad_reduced(byte_pad_reduced),
    .byte_pad_pull_up(byte_pad_pull_up),
    .byte_pad_pull_down(byte_pad_pull_down),
    .byte_edge_rising(byte_edge_rising), .six_port_out(six_port_out),
    .six_port_dir(six_port_dir), .six_pad_out(six_pad_out),
    .six_pad_oe(six_pad_oe), .six_pad_pull_up(six_pad_pull_up),
    .six_pad_pull_down(six_pad_pull_down));
  pad_model pads (.clk(clk), .pad_out(byte_pad_out), .pad_oe(byte_pad_oe),
    .pull_up(byte_pad_pull_up), .pull_down(byte_pad_pull_down),
    .ext_on(ext_on), .ext_level(ext_level), .short_low(short_low),
    .pin(byte_pin_in));

  always #12.5 clk = ~clk;

  // Guard far above the 166 cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One transfer; waits an edge first so releases never collide
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    // No fixed wait assumed; only the cycle guard ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk({7'h00, e}, 8'h00);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 8'h00, q, e);
    chk(q[7:0], x);
    chk({7'h00, e}, 8'h00);
  endtask : rd

  // Reset values; outside driver holds pins at a5
  task automatic t_reset;
    rd(SPE, 8'h3f);
    rd(SPOL, 8'h00);
    rd(SOD, 8'h00);
    rd(BDAT, 8'ha5);
    rd(BMIR, 8'ha5);
    rd(BDIR, 8'h00);
    rd(BDRV, 8'h00);
    rd(BPE, 8'h00);
    rd(BPOL, 8'h00);
    chk(byte_pad_out, 8'h00);
    chk(byte_pad_pull_up | byte_pad_pull_down, 8'h00);
    chk({2'b00, six_pad_pull_up}, 8'h3f);
  endtask : t_reset

  // Low nibble out; a short on bit 2 shows only in the mirror
  task automatic t_dir;
    wr(BDAT, 8'h3c);
    wr(BDIR, 8'h0f);
    repeat (2) @(posedge clk);
    chk(byte_pad_oe, 8'h0f);
    chk(byte_pad_out, 8'h3c);
    rd(BDAT, 8'hac);
    short_low <= 8'h04;
    repeat (3) @(posedge clk);
    rd(BMIR, 8'ha8);
    rd(BDAT, 8'hac);
    short_low <= 8'h00;
  endtask : t_dir

  // Read-only mirror, masked strobe, unmapped and misaligned places
  task automatic t_refuse;
    logic [31:0] q;
    logic        e;
    wr(BMIR, 8'hff);
    rd(BMIR, 8'hac);
    rd(BDAT, 8'hac);
    pstrb <= 4'h0;
    wr(BDIR, 8'hff);
    pstrb <= 4'hf;
    apb(1'b0, 8'h7c, 8'h00, q, e);
    chk({7'h00, e}, 8'h01);
    chk(q[7:0], 8'h00);
    apb(1'b1, BDIR + 8'h01, 8'h00, q, e);
    chk({7'h00, e}, 8'h01);
    rd(BDIR, 8'h0f);
  endtask : t_refuse

  // Byte pulls for two polarities, then pulls alone hold the input pins 7..4
  task automatic t_bpull;
    logic [7:0] p;
    wr(BDRV, 8'hff);
    wr(BPE, 8'hff);
    for (int i = 0; i < 2; i++) begin
      p = (i == 0) ? 8'hf0 : 8'h33;
      wr(BPOL, p);
      repeat (2) @(posedge clk);
      chk(byte_pad_reduced, 8'h0f);
      chk(byte_pad_pull_up, 8'hf0 & ~p);
      chk(byte_pad_pull_down, 8'hf0 & p);
      chk(byte_edge_rising, p);
      rd(BPOL, p);
    end
    ext_on <= 8'h00;
    repeat (3) @(posedge clk);
    rd(BMIR, 8'hcc);
    ext_on <= 8'hff;
  endtask : t_bpull

  // Six-bit pads with open-drain on, then push-pull with fewer pulls
  task automatic t_six;
    logic [5:0] f, p, n, eo, eoe, eup, edn;
    // Pins 3..0 outputs driving 0101, pins 5..4 inputs
    six_port_dir <= 6'h0f;
    six_port_out <= 6'h05;
    for (int i = 0; i < 2; i++) begin
      f   = (i == 0) ? 6'h13 : 6'h00;
      p   = (i == 0) ? 6'h2a : 6'h15;
      n   = (i == 0) ? 6'h3f : 6'h3c;
      // Expected pad controls worked out pin by pin
      eo  = (i == 0) ? 6'h04 : 6'h05;
      eoe = (i == 0) ? 6'h0e : 6'h0f;
      eup = (i == 0) ? 6'h11 : 6'h20;
      edn = (i == 0) ? 6'h22 : 6'h10;
      wr(SOD, {2'b00, f});
      wr(SPOL, {2'b00, p});
      wr(SPE, {2'b00, n});
      repeat (2) @(posedge clk);
      chk({2'b00, six_pad_out}, {2'b00, eo});
      chk({2'b00, six_pad_oe}, {2'b00, eoe});
      chk({2'b00, six_pad_pull_up}, {2'b00, eup});
      chk({2'b00, six_pad_pull_down}, {2'b00, edn});
      rd(SOD, {2'b00, f});
    end
  endtask : t_six

  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_dir();
    t_refuse();
    t_bpull();
    t_six();
    test_done();
  end
endmodule : port_pad_config_regs_bench

bind port_pad_config_regs port_pad_assertions #(.BYTE_W(BYTE_W),
  .SIX_W(SIX_W)) u_chk (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .byte_pad_oe(byte_pad_oe), .byte_pad_reduced(byte_pad_reduced),
  .byte_pad_pull_up(byte_pad_pull_up),
  .byte_pad_pull_down(byte_pad_pull_down),
  .byte_edge_rising(byte_edge_rising), .six_port_out(six_port_out),
  .six_port_dir(six_port_dir), .six_pad_out(six_pad_out),
  .six_pad_oe(six_pad_oe), .six_pad_pull_up(six_pad_pull_up),
  .six_pad_pull_down(six_pad_pull_down));
